/* File: hw/ssr_pkg.sv */
// Purpose: Shared constants and types for the start-stop serial receiver
// Assumes: 100 MHz core clock, line marking = 1, spacing = 0
// Notes: Element rate and sense stage length are defaults only
package ssr_pkg;

    // Clock and element rate
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned BAUD_HZ = 110;
    // Cycles per element, rounded down
    localparam int unsigned BIT_CYCLES_DEF = CLK_HZ / BAUD_HZ;

    // Widths
    localparam int CNT_W = 24;
    localparam int DATA_BITS = 8;
    localparam int SENSE_LINES = 10;
    localparam int PHASE_W = 7;
    localparam int EV_W = 4;

    // Sampling phase scale, centre setting and limit
    localparam logic [PHASE_W-1:0] PHASE_CENTRE = 7'h3C;
    localparam logic [PHASE_W-1:0] PHASE_MAX = 7'h78;
    localparam int unsigned PHASE_STEPS = 240;

    // Fractions and multiples of an element used to place events
    localparam int unsigned CLEAR_DIV = 8;
    localparam int unsigned LOCK_DIV = 4;
    localparam int unsigned TRIP_DIV = 8;
    localparam int unsigned HALF_DIV = 2;
    localparam int unsigned STOP_ELEM = 9;

    // Sense stage placement as fractions of its own cycle
    localparam int unsigned SENSE_EARLY_DIV = 8;
    localparam int unsigned SENSE_LATE_NUM = 7;
    localparam int unsigned SENSE_LATE_DEN = 8;

    // Receive cycle event sequence
    localparam logic [EV_W-1:0] EV_START = 4'h0;
    localparam logic [EV_W-1:0] EV_CLEAR = 4'h1;
    localparam logic [EV_W-1:0] EV_LOCK = 4'h2;
    localparam logic [EV_W-1:0] EV_BIT1 = 4'h3;
    localparam logic [EV_W-1:0] EV_BIT8 = 4'hA;
    localparam logic [EV_W-1:0] EV_TRIP = 4'hB;
    localparam logic [EV_W-1:0] EV_END = 4'hC;
    localparam logic [EV_W-1:0] EV_DATA_BASE = 4'h2;

    // Line levels
    localparam logic LINE_MARK = 1'b1;
    localparam logic LINE_SPACE = 1'b0;

    typedef enum logic {
        RX_IDLE,
        RX_CYCLE
    } ssr_rx_state_t;

    // One received character, bit 1 in position 0
    typedef struct packed {
        logic [DATA_BITS-1:0] bits;
    } ssr_char_t;

    // Sense stage outputs
    typedef struct packed {
        logic [SENSE_LINES-1:0] lines;
        logic funcTrig;
    } ssr_sense_t;

endpackage

/* File: hw/ssr_receiver.sv */
// Purpose: Receive side of a start-stop serial character link
// Assumes: Line idles marking (1); phase setting 0..120, centre 60
// Notes: Downstream decoding and printing live outside this block
`timescale 1ns/1ns

module ssr_receiver #(
    parameter int unsigned BIT_CYCLES = ssr_pkg::BIT_CYCLES_DEF,
    parameter int unsigned SENSE_CYCLES = ssr_pkg::BIT_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Serial line and sampling phase knob
    input wire logic lineIn,
    input wire logic [ssr_pkg::PHASE_W-1:0] phaseSet,
    // Received character and cycle status
    output ssr_pkg::ssr_char_t charOut,
    output logic rxBusy,
    output logic sampleHold,
    output logic senseTrip,
    // Sensing stage
    output logic [ssr_pkg::SENSE_LINES-1:0] senseLines,
    output logic funcTrig,
    output logic senseBusy
);

    localparam logic [ssr_pkg::CNT_W-1:0] BIT_LEN =
        ssr_pkg::CNT_W'(BIT_CYCLES);
    localparam logic [ssr_pkg::CNT_W-1:0] PHASE_STEP =
        ssr_pkg::CNT_W'(BIT_CYCLES / ssr_pkg::PHASE_STEPS);
    // Bits needed to index one data position
    localparam int POS_W = $clog2(ssr_pkg::DATA_BITS);

    ////////////////////////////////////////////////////////////////////////
    // Event timing, measured from the start detection edge
    //
    // Event schedule, in clocks after start detection, with B the
    // element length and ph the sample offset taken from the knob:
    //   start   0                 spacing seen while idle
    //   clear   B/8               previous selections dropped
    //   lock    B/4               hold marker raised for the samples
    //   bit k   k*B + ph          k from 1 to 8, one per data element
    //   trip    8*B + ph + B/8    latch loaded, sense stage started
    //   end     9*B + ph          inside the stop element, cycle over
    // Start, clear, lock, the eight samples and the trip make twelve
    // timed events; the end slot only closes the cycle.
    // Slots grow strictly with the event index, so a single compare
    // against the current index is enough and none can be skipped.
    // Limitation: ph stays below B, so every sample lands inside its
    // own element and the end slot inside the stop element for any B;
    // the knob moves ph only while B is at least the number of phase
    // steps, shorter elements make the knob step zero and the phase fixed.
    // Trade-off: one shared counter and comparator instead of a
    // counter per event keeps the logic small but makes the
    // schedule purely sequential.

    // Offset of the sample point inside each element
    function automatic logic [ssr_pkg::CNT_W-1:0] phaseOffset(
        input logic [ssr_pkg::PHASE_W-1:0] setting
    );
        logic [ssr_pkg::PHASE_W-1:0] s;
        logic [ssr_pkg::CNT_W-1:0] base;
        s = (setting > ssr_pkg::PHASE_MAX) ? ssr_pkg::PHASE_MAX : setting;
        base = BIT_LEN / ssr_pkg::CNT_W'(ssr_pkg::HALF_DIV)
             + PHASE_STEP * ssr_pkg::CNT_W'(ssr_pkg::PHASE_CENTRE);
        // Low settings sample late, high settings sample early
        phaseOffset = base - PHASE_STEP * ssr_pkg::CNT_W'(s);
    endfunction

    // True for the eight data sampling events
    function automatic logic isDataEv(
        input logic [ssr_pkg::EV_W-1:0] ev
    );
        isDataEv = (ev >= ssr_pkg::EV_BIT1) && (ev <= ssr_pkg::EV_BIT8);
    endfunction

    // Cycle count at which a given event fires
    function automatic logic [ssr_pkg::CNT_W-1:0] evTime(
        input logic [ssr_pkg::EV_W-1:0] ev,
        input logic [ssr_pkg::CNT_W-1:0] ph
    );
        logic [ssr_pkg::CNT_W-1:0] k;
        k = ssr_pkg::CNT_W'(ev - ssr_pkg::EV_DATA_BASE);
        if (ev == ssr_pkg::EV_CLEAR) begin
            evTime = BIT_LEN / ssr_pkg::CNT_W'(ssr_pkg::CLEAR_DIV);
        end else if (ev == ssr_pkg::EV_LOCK) begin
            evTime = BIT_LEN / ssr_pkg::CNT_W'(ssr_pkg::LOCK_DIV);
        end else if (isDataEv(ev)) begin
            evTime = k * BIT_LEN + ph;
        end else if (ev == ssr_pkg::EV_TRIP) begin
            evTime = ssr_pkg::CNT_W'(ssr_pkg::DATA_BITS) * BIT_LEN + ph
                   + BIT_LEN / ssr_pkg::CNT_W'(ssr_pkg::TRIP_DIV);
        end else begin
            // End of cycle lands inside the stop element
            evTime = ssr_pkg::CNT_W'(ssr_pkg::STOP_ELEM) * BIT_LEN + ph;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    // Assertion stays asynchronous so a dead clock still clears state;
    // only the release edge is retimed, so no flop wakes up a cycle
    // ahead of its neighbours.
    logic rstSync1_r;
    logic rstSync2_r;
    logic rstnSync;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end

    assign rstnSync = rstSync2_r;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts once two agree
    // The agreement stage costs one clock of latency but keeps a
    // single unsettled sample from ever starting a false cycle or
    // moving the phase setting for one clock only.
    logic lineS1_r;
    logic lineS2_r;
    logic lineS3_r;
    logic lineState_r;
    logic lineState_nxt;
    logic [ssr_pkg::PHASE_W-1:0] phS1_r;
    logic [ssr_pkg::PHASE_W-1:0] phS2_r;
    logic [ssr_pkg::PHASE_W-1:0] phS3_r;
    logic [ssr_pkg::PHASE_W-1:0] phState_r;
    logic [ssr_pkg::PHASE_W-1:0] phState_nxt;

    // Filtered levels only move when stages two and three agree
    always_comb begin
        lineState_nxt = lineState_r;
        phState_nxt = phState_r;
        if (lineS2_r == lineS3_r) begin
            lineState_nxt = lineS3_r;
        end
        if (phS2_r == phS3_r) begin
            phState_nxt = phS3_r;
        end
    end

    // Line resets to marking so reset never looks like a start
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            lineS1_r <= ssr_pkg::LINE_MARK;
            lineS2_r <= ssr_pkg::LINE_MARK;
            lineS3_r <= ssr_pkg::LINE_MARK;
            lineState_r <= ssr_pkg::LINE_MARK;
            phS1_r <= ssr_pkg::PHASE_CENTRE;
            phS2_r <= ssr_pkg::PHASE_CENTRE;
            phS3_r <= ssr_pkg::PHASE_CENTRE;
            phState_r <= ssr_pkg::PHASE_CENTRE;
        end else begin
            lineS1_r <= lineIn;
            lineS2_r <= lineS1_r;
            lineS3_r <= lineS2_r;
            lineState_r <= lineState_nxt;
            phS1_r <= phaseSet;
            phS2_r <= phS1_r;
            phS3_r <= phS2_r;
            phState_r <= phState_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive cycle sequencer
    ssr_pkg::ssr_rx_state_t state_r;
    ssr_pkg::ssr_rx_state_t state_nxt;
    logic [ssr_pkg::CNT_W-1:0] cycCnt_r;
    logic [ssr_pkg::CNT_W-1:0] cycCnt_nxt;
    logic [ssr_pkg::EV_W-1:0] evIdx_r;
    logic [ssr_pkg::EV_W-1:0] evIdx_nxt;
    logic [ssr_pkg::CNT_W-1:0] phOff_r;
    logic [ssr_pkg::CNT_W-1:0] phOff_nxt;
    logic [ssr_pkg::DATA_BITS-1:0] sel_r;
    logic [ssr_pkg::DATA_BITS-1:0] sel_nxt;
    ssr_pkg::ssr_char_t charOut_nxt;
    logic rxBusy_nxt;
    logic sampleHold_nxt;
    logic senseTrip_nxt;
    logic evHit;
    logic [ssr_pkg::EV_W-1:0] bitPos;
    logic evClear;
    logic evLock;
    logic evData;
    logic evTrip;
    logic evEnd;

    // Event fires when the cycle count reaches its slot
    assign evHit = (cycCnt_r == evTime(evIdx_r, phOff_r));
    assign bitPos = evIdx_r - ssr_pkg::EV_BIT1;

    // One strobe per event, only while a cycle runs
    always_comb begin
        evClear = 1'b0;
        evLock = 1'b0;
        evData = 1'b0;
        evTrip = 1'b0;
        evEnd = 1'b0;
        if (state_r == ssr_pkg::RX_CYCLE && evHit) begin
            evClear = (evIdx_r == ssr_pkg::EV_CLEAR);
            evLock = (evIdx_r == ssr_pkg::EV_LOCK);
            evData = isDataEv(evIdx_r);
            evTrip = (evIdx_r == ssr_pkg::EV_TRIP);
            evEnd = (evIdx_r == ssr_pkg::EV_END);
        end
    end

    // Sequence: start, clear, lock, bits 1..8, trip, then end
    always_comb begin
        state_nxt = state_r;
        cycCnt_nxt = cycCnt_r;
        evIdx_nxt = evIdx_r;
        phOff_nxt = phOff_r;
        rxBusy_nxt = rxBusy;
        sampleHold_nxt = sampleHold;
        senseTrip_nxt = 1'b0;
        unique case (state_r)
            ssr_pkg::RX_IDLE: begin
                // Marking line keeps the receiver idle
                if (lineState_r == ssr_pkg::LINE_SPACE) begin
                    state_nxt = ssr_pkg::RX_CYCLE;
                    // Counter restarts here; phase frozen per character
                    cycCnt_nxt = '0;
                    phOff_nxt = phaseOffset(phState_r);
                    evIdx_nxt = ssr_pkg::EV_CLEAR;
                    rxBusy_nxt = 1'b1;
                end
            end
            ssr_pkg::RX_CYCLE: begin
                // Line is not watched for aborts; the cycle always ends
                cycCnt_nxt = cycCnt_r + 1'b1;
                if (evHit) begin
                    evIdx_nxt = evIdx_r + 1'b1;
                    if (evLock) begin
                        sampleHold_nxt = 1'b1;
                    end
                    if (evTrip) begin
                        senseTrip_nxt = 1'b1;
                        sampleHold_nxt = 1'b0;
                    end
                    if (evEnd) begin
                        // Stop element is marking, so idle stays idle
                        state_nxt = ssr_pkg::RX_IDLE;
                        evIdx_nxt = ssr_pkg::EV_START;
                        rxBusy_nxt = 1'b0;
                    end
                end
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            state_r <= ssr_pkg::RX_IDLE;
            cycCnt_r <= '0;
            evIdx_r <= ssr_pkg::EV_START;
            phOff_r <= '0;
            rxBusy <= 1'b0;
            sampleHold <= 1'b0;
            senseTrip <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cycCnt_r <= cycCnt_nxt;
            evIdx_r <= evIdx_nxt;
            phOff_r <= phOff_nxt;
            rxBusy <= rxBusy_nxt;
            sampleHold <= sampleHold_nxt;
            senseTrip <= senseTrip_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Select register and output latch, driven by the event strobes
    // Cleared early in each cycle so a stale mark cannot leak into
    // the next character; the latch itself only moves at the trip.
    always_comb begin
        sel_nxt = sel_r;
        charOut_nxt = charOut;
        if (evClear) begin
            sel_nxt = '0;
        end
        if (evData) begin
            // Mark selects, space leaves position clear
            sel_nxt[bitPos[POS_W-1:0]] = lineState_r;
        end
        if (evTrip) begin
            charOut_nxt.bits = sel_r;
        end
    end

    // Latch registers; the output holds its value between trips
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            sel_r <= '0;
            charOut <= '0;
        end else begin
            sel_r <= sel_nxt;
            charOut <= charOut_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output sensing stage, fed from the output latch
    ssr_pkg::ssr_sense_t sense;

    // Trip pulse and latch update land together; latch it one cycle on
    ssr_sense_stage #(
        .SENSE_CYCLES(SENSE_CYCLES)
    ) u_sense (
        .clk(clk),
        .rstnSync(rstnSync),
        .trig(senseTrip),
        .latched(charOut),
        .sense(sense),
        .busy(senseBusy)
    );

    assign senseLines = sense.lines;
    assign funcTrig = sense.funcTrig;

endmodule

/* File: hw/ssr_sense_stage.sv */
// Purpose: Output sensing stage, one timed cycle per trigger
// Assumes: Trigger and bits come from the same clock domain
// Notes: A trigger while a cycle runs is ignored
`timescale 1ns/1ns
module ssr_sense_stage #(
    parameter int unsigned SENSE_CYCLES = ssr_pkg::BIT_CYCLES_DEF
) (
    // Clock and synchronised reset
    input wire logic clk,
    input wire logic rstnSync,
    // Start request and latched character
    input wire logic trig,
    input wire ssr_pkg::ssr_char_t latched,
    // Sensing lines and function trigger
    output ssr_pkg::ssr_sense_t sense,
    output logic busy
);

    localparam logic [ssr_pkg::CNT_W-1:0] EARLY_AT =
        ssr_pkg::CNT_W'(SENSE_CYCLES / ssr_pkg::SENSE_EARLY_DIV);
    localparam logic [ssr_pkg::CNT_W-1:0] LATE_AT =
        ssr_pkg::CNT_W'(SENSE_CYCLES * ssr_pkg::SENSE_LATE_NUM
                        / ssr_pkg::SENSE_LATE_DEN);
    localparam logic [ssr_pkg::CNT_W-1:0] LAST_AT =
        ssr_pkg::CNT_W'(SENSE_CYCLES - 1);

    logic [ssr_pkg::CNT_W-1:0] cnt_r;
    logic [ssr_pkg::CNT_W-1:0] cnt_nxt;
    logic busy_nxt;
    ssr_pkg::ssr_sense_t sense_nxt;

    ////////////////////////////////////////////////////////////////////////
    // One cycle per trigger, never re-entered while running
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy;
        sense_nxt = sense;
        sense_nxt.funcTrig = 1'b0;
        if (!busy) begin
            if (trig) begin
                busy_nxt = 1'b1;
                cnt_nxt = '0;
                // Spacing positions stay inactive, marking ones go active
                sense_nxt.lines = {2'b00, latched.bits};
            end
        end else begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == EARLY_AT) begin
                sense_nxt.funcTrig = 1'b1;
            end
            if (cnt_r == LATE_AT) begin
                sense_nxt.lines = '0;
            end
            if (cnt_r == LAST_AT) begin
                busy_nxt = 1'b0;
            end
        end
    end

    // Registers only
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            cnt_r <= '0;
            busy <= 1'b0;
            sense <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            busy <= busy_nxt;
            sense <= sense_nxt;
        end
    end

endmodule

/* File: verification/ssr_line_tx.sv */
// Purpose: Behavioural start-stop line transmitter feeding the receiver
// Assumes: Called at a falling clock edge
// Notes: Always sends a marking stop element
`timescale 1ns/1ns
module ssr_line_tx #(
    parameter int unsigned BIT_CYCLES = 480
) (
    // Clock
    input wire logic clk,
    // Serial line
    output logic lineOut
);
    // Line rests marking between characters
    initial begin
        lineOut = ssr_pkg::LINE_MARK;
    end

    ////////////////////////////////////////////////////////////////////
    // Start, eight data elements bit 1 first, then stop
    task automatic sendChar(input logic [7:0] d);
        int k;
        lineOut = ssr_pkg::LINE_SPACE;
        repeat (BIT_CYCLES) @(negedge clk);
        for (k = 0; k < 8; k++) begin
            lineOut = d[k];
            repeat (BIT_CYCLES) @(negedge clk);
        end
        lineOut = ssr_pkg::LINE_MARK;
        repeat (BIT_CYCLES) @(negedge clk);
    endtask
endmodule

/* File: verification/ssr_receiver_assertions.sv */
// Purpose: Port-level checks on the start-stop serial receiver
// Assumes: Single clock domain, rstn async active low
// Notes: Bound into every ssr_receiver instance
`timescale 1ns/1ns
module ssr_receiver_assertions #(
    parameter int unsigned BIT_CYCLES = ssr_pkg::BIT_CYCLES_DEF,
    parameter int unsigned SENSE_CYCLES = ssr_pkg::BIT_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Line side
    input wire logic lineIn,
    input wire logic [ssr_pkg::PHASE_W-1:0] phaseSet,
    // Receive outputs
    input wire ssr_pkg::ssr_char_t charOut,
    input wire logic rxBusy,
    input wire logic sampleHold,
    input wire logic senseTrip,
    // Sense stage outputs
    input wire logic [ssr_pkg::SENSE_LINES-1:0] senseLines,
    input wire logic funcTrig,
    input wire logic senseBusy
);
    logic [31:0] busyCnt_r;
    logic [31:0] busyCnt_nxt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////
    // Busy length counter, so a cut-short cycle shows up at its end
    always_comb begin
        busyCnt_nxt = rxBusy ? busyCnt_r + 32'h0000_0001 : 32'h0000_0000;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busyCnt_r <= 32'h0000_0000;
        end else begin
            busyCnt_r <= busyCnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive cycle ordering
    AST_IDLE_ON_MARK: assert property ((!rxBusy && lineIn)[*6] |=> !rxBusy)
        else $error("receiver left idle on a marking line");
    AST_IDLE_START: assert property ((!rxBusy && !lineIn)[*6] |-> ##[0:4] rxBusy)
        else $error("spacing start not taken");
    AST_FULL_CYCLE: assert property ($fell(rxBusy) |-> busyCnt_r >= 32'(9 * BIT_CYCLES))
        else $error("receive cycle ended early");
    AST_HOLD_IN_CYCLE: assert property (sampleHold |-> rxBusy)
        else $error("sample hold outside a cycle");
    AST_LOCK_AFTER_START: assert property ($rose(sampleHold) |-> $past(rxBusy))
        else $error("lock step before start");
    AST_TRIP_CLOSES_HOLD: assert property (senseTrip |-> $fell(sampleHold) && rxBusy)
        else $error("trip not at end of sampling");
    AST_TRIP_PULSE: assert property (senseTrip |=> !senseTrip)
        else $error("trip longer than one cycle");
    AST_CHAR_ONLY_AT_TRIP: assert property (!senseTrip |-> $stable(charOut))
        else $error("output latch changed off the trip");

    ////////////////////////////////////////////////////////////////////
    // Sense stage
    AST_SENSE_FOLLOWS_TRIP: assert property (senseTrip |-> ##[1:3]
        (senseBusy && senseLines == {2'h0, charOut.bits}))
        else $error("sense stage did not present the latch");
    AST_SPARE_QUIET: assert property (senseLines[9:8] == 2'h0)
        else $error("spare sensing line active");
    AST_MARK_ONLY: assert property ((senseLines[7:0] & ~charOut.bits) == 8'h00)
        else $error("spacing position drove its line");
    AST_REST_OUTSIDE: assert property (!senseBusy |-> senseLines == 10'h000)
        else $error("sensing lines not at rest");
    AST_FUNC_IN_SENSE: assert property (funcTrig |-> senseBusy ##1 !funcTrig)
        else $error("function trigger outside sensing");

    // Main scenario reached
    cover property (senseTrip);
endmodule

bind ssr_receiver ssr_receiver_assertions #(
    .BIT_CYCLES(BIT_CYCLES),
    .SENSE_CYCLES(SENSE_CYCLES)
) i_chk (.clk(clk), .rstn(rstn), .lineIn(lineIn), .phaseSet(phaseSet),
    .charOut(charOut), .rxBusy(rxBusy), .sampleHold(sampleHold),
    .senseTrip(senseTrip), .senseLines(senseLines), .funcTrig(funcTrig),
    .senseBusy(senseBusy));

/* File: verification/ssr_receiver_test.sv */
// Purpose: Self-checking bench for the start-stop serial receiver
// Assumes: Shortened element and sense lengths for run time
// Notes: Inputs change on the falling edge only
`timescale 1ns/1ns
module ssr_receiver_test;
    localparam int unsigned B = 480;
    localparam int unsigned S = 240;

    logic clk;
    logic rstn;
    logic lineIn;
    logic [ssr_pkg::PHASE_W-1:0] phaseSet;
    ssr_pkg::ssr_char_t charOut;
    logic rxBusy;
    logic sampleHold;
    logic senseTrip;
    logic [ssr_pkg::SENSE_LINES-1:0] senseLines;
    logic funcTrig;
    logic senseBusy;
    int n_fail;
    int checks;

    ssr_receiver #(.BIT_CYCLES(B), .SENSE_CYCLES(S)) i_dut (
        .clk(clk), .rstn(rstn), .lineIn(lineIn), .phaseSet(phaseSet),
        .charOut(charOut), .rxBusy(rxBusy), .sampleHold(sampleHold),
        .senseTrip(senseTrip), .senseLines(senseLines),
        .funcTrig(funcTrig), .senseBusy(senseBusy));

    ssr_line_tx #(.BIT_CYCLES(B)) i_tx (.clk(clk), .lineOut(lineIn));

    ////////////////////////////////////////////////////////////////////
    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task tally_and_finish;
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Bounded wait for the trip pulse; n counts cycles from entry
    task waitTrip(output int n);
        n = 0;
        while (senseTrip !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 10 * B) begin
                n_fail++;
                $display("wrong value at %0t: no trip seen", $time);
                tally_and_finish();
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // One frame, then latch, sensing lines and trigger count
    task runChar(input logic [7:0] d, output int n);
        int f;
        int k;
        f = 0;
        fork
            i_tx.sendChar(d);
            begin
                waitTrip(n);
                chk({2'h0, charOut.bits}, {2'h0, d});
                for (k = 0; k < S + 8; k++) begin
                    @(negedge clk);
                    if (funcTrig === 1'b1) f++;
                    if (k == S / 2) chk(senseLines, {2'h0, d});
                end
                chk(senseLines, 10'h000);
                chk(10'(f), 10'h001);
            end
        join
    endtask

    // Back-to-back frames; all-ones then all-zeros exposes stale bits
    task charScenario;
        logic [7:0] tbl [6];
        int i;
        int n;
        tbl = '{8'h48, 8'hFF, 8'h00, 8'hA5, 8'h01, 8'h80};
        for (i = 0; i < 6; i++) begin
            runChar(tbl[i], n);
        end
    endtask

    // Phase knob moves the sample points and the trip by B/240 a step
    task phaseScenario;
        int t0;
        int t60;
        int t120;
        phaseSet = 7'h00;
        repeat (10) @(negedge clk);
        runChar(8'h5A, t0);
        phaseSet = 7'h3C;
        repeat (10) @(negedge clk);
        runChar(8'hC3, t60);
        phaseSet = 7'h78;
        repeat (10) @(negedge clk);
        runChar(8'h3C, t120);
        chk(10'(t0 - t60), 10'h078);
        chk(10'(t60 - t120), 10'h078);
        chk(10'(t60 > 4140 && t60 < 4150), 10'h001);
    endtask

    // Marking line after a stop element keeps the receiver idle
    task idleScenario;
        int k;
        int busy;
        busy = 0;
        for (k = 0; k < B; k++) begin
            @(negedge clk);
            if (rxBusy !== 1'b0) busy++;
        end
        chk(10'(busy), 10'h000);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        n_fail = 0;
        checks = 0;
        rstn = 1'b0;
        phaseSet = 7'h3C;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (5) @(negedge clk);
        charScenario();
        idleScenario();
        phaseScenario();
        idleScenario();
        tally_and_finish();
    end
endmodule
